/* File: verilog/ipx_core.sv */
// Purpose: Interrupt priority selection and external request collection
// Assumes: Inputs synchronous to i_clock; one boundary pulse per instruction
// Notes:   Registers on Avalon-MM; reads complete with one wait state
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// (RULE1) Reset and machine check preempt everything
// (RULE2) Reset taken only on fresh trigger edge
// (RULE3) Machine check gated by guard bit
// (RULE4) Only one ordered interrupt per boundary
// (RULE5) First found condition wins, others dropped
// (RULE6) Handler saves state without faulting
// (RULE7) External lowest, only when enabled, alone
// (RULE8) Any taken interrupt clears external enable
// (RULE9) Software keeps enable off until saved
// (RULE10) Fetch failure ranks just above external
// (RULE11) Instruction interrupts rank above fetch failure
// (RULE12) Fixed non-I/O: alignment, storage, trace
// (RULE13) Fixed I/O: only I/O storage interrupt; code still takes trace when it is the only condition
// (RULE14) Float load/store: unavailable, alignment, storage, trace
// (RULE15) Alignment for I/O float copies segment flag
// (RULE16) Float arithmetic: unavailable, program, trace
// (RULE17) Other float: unavailable then trace
// (RULE18) Return and state write: privileged, then float
// (RULE19) Sixty-four sources form one combined signal
// (RULE20) Request only when combined and enable set
// (RULE21) Mask gates latched summary bits
// (RULE22) No hardware priority among summary bits
// (RULE23) Summary latches source regardless of mask
// (RULE24) Summary read clears; mask read keeps
// (RULE25) Summary write ORs; mask write replaces
// (RULE26) Source during access never lost nor doubled
// (RULE27) One winner encoded per boundary
module ipx_core
    import ipx_pkg::*;
#(
    parameter int NSRC = IPX_NSRC
) (
    input  wire logic              i_clock,
    input  wire logic              i_srst,
    input  wire logic [IPX_AW-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    output logic      [31:0]       o_avs_readdata,
    output logic                   o_avs_waitrequest,
    input  wire logic [NSRC-1:0]   i_src_req,
    input  wire logic              i_sys_reset_trig,
    input  wire logic              i_mcheck,
    input  wire logic              i_boundary,
    input  wire ipx_cond_t         i_cond,
    input  wire logic              i_fetch_fail,
    input  wire logic              i_rfi,
    output ipx_vec_t               o_vector,
    output logic                   o_vector_valid,
    output logic                   o_cause_io,
    output logic                   o_ext_request,
    output logic                   o_combined
);
    logic [NSRC-1:0] sum_q;
    logic [NSRC-1:0] sum_d;
    logic [NSRC-1:0] mask_q;
    logic [NSRC-1:0] mask_d;
    logic [31:0]     ctrl_q;
    logic [31:0]     ctrl_d;
    logic [31:0]     cause_q;
    logic [31:0]     cause_d;
    logic            rst_trig_q;
    logic            rd_pend_q;
    logic [31:0]     rdata_q;
    ipx_vec_t        vec_q;
    logic            vvalid_q;
    logic            cio_q;

    wire logic ext_en = ctrl_q[IPX_CTL_XEN];
    wire logic mcg    = ctrl_q[IPX_CTL_MCG];

    // Bus decode; reads take one wait state so clear-on-read is atomic
    wire logic wr_m0 = i_avs_write && (i_avs_address == IPX_OFF_MASK0);
    wire logic wr_m1 = i_avs_write && (i_avs_address == IPX_OFF_MASK1);
    wire logic wr_s0 = i_avs_write && (i_avs_address == IPX_OFF_SUM0);
    wire logic wr_s1 = i_avs_write && (i_avs_address == IPX_OFF_SUM1);
    wire logic wr_ct = i_avs_write && (i_avs_address == IPX_OFF_CTRL);
    wire logic rd_go = i_avs_read && !rd_pend_q;
    wire logic rd_s0 = rd_go && (i_avs_address == IPX_OFF_SUM0);
    wire logic rd_s1 = rd_go && (i_avs_address == IPX_OFF_SUM1);

    // Combined request and processor request
    wire logic combined = |(sum_q & mask_q);   // [RULE19] [RULE21] [RULE22]
    wire logic ext_req  = combined && ext_en;  // [RULE20]

    // Unaligned I/O float access raises alignment, storage otherwise
    function automatic ipx_vec_t ipx_align_or_dstor(input ipx_cond_t c);
        ipx_vec_t v;
        if (c.align) begin
            v = IPX_V_ALIGN;                           // [RULE15]
        end else begin
            v = IPX_V_DSTOR;
        end
        return v;
    endfunction

    // Fixed load/store; an I/O segment folds alignment, storage and privilege into storage, trace stays trace
    function automatic ipx_vec_t ipx_pick_fix(input ipx_cond_t c);
        ipx_vec_t v;
        v = IPX_V_NONE;
        if (c.io_seg) begin
            if (c.align || c.dstor || c.priv) begin
                v = IPX_V_DSTOR;                       // [RULE13]
            end else if (c.trace) begin
                v = IPX_V_TRACE;                       // [RULE13]
            end
        end else if (c.align) begin
            v = IPX_V_ALIGN;                           // [RULE12]
        end else if (c.dstor) begin
            v = IPX_V_DSTOR;                           // [RULE12]
        end else if (c.trace) begin
            v = IPX_V_TRACE;                           // [RULE12]
        end
        return v;
    endfunction

    // Float load/store; an I/O segment skips the plain alignment step
    function automatic ipx_vec_t ipx_pick_fls(input ipx_cond_t c);
        ipx_vec_t v;
        v = IPX_V_NONE;
        if (c.fp_unavail) begin
            v = IPX_V_FPUNAV;                          // [RULE14]
        end else if (c.align && !c.io_seg) begin
            v = IPX_V_ALIGN;                           // [RULE14]
        end else if (c.align || c.dstor) begin
            v = ipx_align_or_dstor(c);                 // [RULE15]
        end else if (c.trace) begin
            v = IPX_V_TRACE;                           // [RULE14]
        end
        return v;
    endfunction

    // Per-class ordered selection, first condition found wins
    function automatic ipx_vec_t ipx_pick(input ipx_cond_t c);
        ipx_vec_t v;
        v = IPX_V_NONE;
        case (c.cls)
            IPX_CL_FIX_LS: begin
                v = ipx_pick_fix(c);
            end
            IPX_CL_FP_LS: begin
                v = ipx_pick_fls(c);
            end
            IPX_CL_FP_ARITH: begin
                if (c.fp_unavail) begin
                    v = IPX_V_FPUNAV;                  // [RULE16]
                end else if (c.fp_enabled) begin
                    v = IPX_V_PROG_FP;                 // [RULE16]
                end else if (c.trace) begin
                    v = IPX_V_TRACE;                   // [RULE16]
                end
            end
            IPX_CL_FP_OTHER: begin
                if (c.fp_unavail) begin
                    v = IPX_V_FPUNAV;                  // [RULE17]
                end else if (c.trace) begin
                    v = IPX_V_TRACE;                   // [RULE17]
                end
            end
            IPX_CL_RFI_MTMSR: begin
                if (c.priv) begin
                    v = IPX_V_PROG_PRIV;               // [RULE18]
                end else if (c.fp_enabled) begin
                    v = IPX_V_PROG_FP;                 // [RULE18]
                end
            end
            IPX_CL_TRAP: begin
                v = IPX_V_PROG_TRAP;                   // [RULE11]
            end
            IPX_CL_PRIV: begin
                if (c.priv) begin
                    v = IPX_V_PROG_PRIV;               // [RULE11]
                end else if (c.trace) begin
                    v = IPX_V_TRACE;
                end
            end
            IPX_CL_UNDEF: begin
                v = IPX_V_PROG_INV;                    // [RULE11]
            end
            IPX_CL_SVC: begin
                v = IPX_V_SVC;                         // [RULE11]
            end
            default: begin
                v = IPX_V_NONE;
            end
        endcase
        return v;
    endfunction

    wire ipx_vec_t instr_vec = ipx_pick(i_cond);
    wire logic     rst_take  = i_sys_reset_trig && !rst_trig_q; // [RULE2]
    wire logic     mc_take   = i_mcheck && mcg;                 // [RULE3]

    // Fixed order, first hit wins, lower ones never recorded
    ipx_vec_t win;
    always_comb begin
        if (rst_take) begin
            win = IPX_V_RESET;                        // [RULE1]
        end else if (mc_take) begin
            win = IPX_V_MCHECK;                       // [RULE1]
        end else if (!i_boundary) begin
            win = IPX_V_NONE;                         // [RULE27]
        end else if (instr_vec != IPX_V_NONE) begin
            win = instr_vec;                          // [RULE11]
        end else if (i_fetch_fail) begin
            win = IPX_V_ISTOR;                        // [RULE10]
        end else if (ext_req) begin
            win = IPX_V_EXT;                          // [RULE7]
        end else begin
            win = IPX_V_NONE;                         // [RULE5]
        end
    end

    wire logic taken  = (win != IPX_V_NONE);                  // [RULE4]
    wire logic fp_io_align = (i_cond.cls == IPX_CL_FP_LS) && i_cond.io_seg
                             && (win == IPX_V_ALIGN);

    // Summary: hardware set wins over read clear, write ORs
    always_comb begin
        sum_d = sum_q;
        if (rd_s0) begin
            sum_d[31:0] = 32'h0000_0000;                  // [RULE24]
        end
        if (rd_s1) begin
            sum_d[NSRC-1:32] = '0;                        // [RULE24]
        end
        if (wr_s0) begin
            sum_d[31:0] = sum_q[31:0] | i_avs_writedata;  // [RULE25]
        end
        if (wr_s1) begin
            sum_d[NSRC-1:32] = sum_q[NSRC-1:32] | i_avs_writedata;
        end
        sum_d = sum_d | i_src_req;                        // [RULE23] [RULE26]
    end

    always_comb begin
        mask_d = mask_q;
        if (wr_m0) begin
            mask_d[31:0] = i_avs_writedata;               // [RULE25]
        end
        if (wr_m1) begin
            mask_d[NSRC-1:32] = i_avs_writedata;          // [RULE25]
        end
    end

    // Control: software write, then return sets enable; a taken
    // interrupt comes last so its clear always wins the same cycle
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ct) begin
            ctrl_d = i_avs_writedata & 32'h0000_0003;
        end
        if (i_rfi) begin
            ctrl_d[IPX_CTL_XEN] = 1'b1;
        end
        if (taken) begin
            ctrl_d[IPX_CTL_XEN] = 1'b0;                   // [RULE8]
        end
        if (win == IPX_V_MCHECK) begin
            ctrl_d[IPX_CTL_MCG] = 1'b0;                   // [RULE3]
        end
    end

    always_comb begin
        cause_d = cause_q;
        if (fp_io_align) begin
            cause_d = 32'h0000_0000;
            cause_d[IPX_DSC_TBIT] = i_cond.io_seg;            // [RULE15]
        end
    end

    // Read mux; mask read leaves the mask alone
    logic [31:0] rmux;
    always_comb begin
        case (i_avs_address)
            IPX_OFF_MASK0: rmux = mask_q[31:0];
            IPX_OFF_MASK1: rmux = mask_q[NSRC-1:32];
            IPX_OFF_SUM0:  rmux = sum_q[31:0];
            IPX_OFF_SUM1:  rmux = sum_q[NSRC-1:32];
            IPX_OFF_CTRL:  rmux = ctrl_q;
            IPX_OFF_STAT:  rmux = {29'h0, rst_trig_q, combined, ext_req};
            IPX_OFF_CAUSE: rmux = cause_q;
            default:       rmux = IPX_UNMAP_DATA;
        endcase
    end

    // Summary and mask words
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            sum_q  <= '0;
            mask_q <= '0;
        end else begin
            sum_q  <= sum_d;
            mask_q <= mask_d;
        end
    end

    // Control and cause words; reset leaves guard set, enable clear
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            ctrl_q  <= IPX_CTRL_RST;
            cause_q <= 32'h0000_0000;
        end else begin
            ctrl_q  <= ctrl_d;
            cause_q <= cause_d;
        end
    end

    // Trigger history for the one-shot edge test
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rst_trig_q <= 1'b0;
        end else begin
            rst_trig_q <= i_sys_reset_trig;               // [RULE2]
        end
    end

    // Read path: one wait state keeps the clear-on-read atomic
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rd_pend_q <= 1'b0;
            rdata_q   <= 32'h0000_0000;
        end else begin
            rd_pend_q <= rd_go;
            rdata_q   <= rd_go ? rmux : rdata_q;
        end
    end

    // Winner handed to vector generation, registered on the same edge as the cause
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            vec_q    <= IPX_V_NONE;
            vvalid_q <= 1'b0;
            cio_q    <= 1'b0;
        end else begin
            vec_q    <= win;                              // [RULE27]
            vvalid_q <= taken;
            cio_q    <= fp_io_align;
        end
    end

    assign o_avs_readdata    = rdata_q;
    assign o_avs_waitrequest = i_avs_read && !rd_pend_q;
    assign o_vector          = vec_q;
    assign o_vector_valid    = vvalid_q;
    assign o_cause_io        = cio_q;
    assign o_ext_request     = ext_req;
    assign o_combined        = combined;
endmodule : ipx_core
`default_nettype wire

/* File: common/ipx_pkg.sv */
// Purpose: Shared constants and types for the interrupt priority block
// Assumes: 32-bit Avalon-MM register bus, word addressed by byte offset
// Notes:   Offsets of the summary and mask words follow the I/O map
package ipx_pkg;
    localparam int          IPX_NSRC        = 64;
    localparam int          IPX_AW          = 8;
    localparam logic [7:0]  IPX_OFF_MASK0   = 8'h00;
    localparam logic [7:0]  IPX_OFF_MASK1   = 8'h04;
    localparam logic [7:0]  IPX_OFF_SUM0    = 8'h10;
    localparam logic [7:0]  IPX_OFF_SUM1    = 8'h14;
    localparam logic [7:0]  IPX_OFF_CTRL    = 8'h40;
    localparam logic [7:0]  IPX_OFF_STAT    = 8'h44;
    localparam logic [7:0]  IPX_OFF_CAUSE   = 8'h48;
    localparam int          IPX_CTL_XEN     = 0;
    localparam int          IPX_CTL_MCG     = 1;
    localparam int          IPX_DSC_TBIT    = 14;
    localparam logic [31:0] IPX_CTRL_RST    = 32'h0000_0002;
    localparam logic [31:0] IPX_UNMAP_DATA  = 32'h0000_0000;

    // Instruction classes seen at a boundary
    typedef enum logic [3:0] {
        IPX_CL_NONE, IPX_CL_FIX_LS, IPX_CL_FP_LS, IPX_CL_FP_ARITH,
        IPX_CL_FP_OTHER, IPX_CL_RFI_MTMSR, IPX_CL_TRAP, IPX_CL_PRIV,
        IPX_CL_UNDEF, IPX_CL_SVC
    } ipx_class_t;

    // Winning interrupt codes
    typedef enum logic [3:0] {
        IPX_V_NONE, IPX_V_RESET, IPX_V_MCHECK, IPX_V_ALIGN, IPX_V_DSTOR,
        IPX_V_TRACE, IPX_V_FPUNAV, IPX_V_PROG_FP, IPX_V_PROG_PRIV,
        IPX_V_PROG_TRAP, IPX_V_PROG_INV, IPX_V_SVC, IPX_V_ISTOR, IPX_V_EXT
    } ipx_vec_t;

    // Conditions raised by the instruction at the boundary
    typedef struct packed {
        ipx_class_t cls;
        logic       io_seg;
        logic       align;
        logic       dstor;
        logic       trace;
        logic       fp_unavail;
        logic       fp_enabled;
        logic       priv;
    } ipx_cond_t;
endpackage : ipx_pkg

/* File: tb/ipx_core_asserts.sv */
// Purpose: Port checks of the interrupt priority block
// Assumes: One clock, synchronous active-high reset
// Notes:   Ordered checks stand aside while reset or check is raised
`timescale 1ns/1ps
`default_nettype none
module ipx_core_asserts
    import ipx_pkg::*;
(
    input wire logic      i_clock,
    input wire logic      i_srst,
    input wire logic      i_sys_reset_trig,
    input wire logic      i_mcheck,
    input wire logic      i_boundary,
    input wire ipx_cond_t i_cond,
    input wire ipx_vec_t  o_vector,
    input wire logic      o_vector_valid,
    input wire logic      o_ext_request,
    input wire logic      o_combined
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // Unordered events preempt, so they are kept out of the ordered cases
    wire logic fix_go = i_boundary && !i_mcheck && !i_sys_reset_trig
                        && i_cond.cls == IPX_CL_FIX_LS;
    sequence s_win(ipx_vec_t v);
        ##1 o_vector_valid && o_vector == v;
    endsequence
    property p_rst; $rose(i_sys_reset_trig)
        |-> s_win(IPX_V_RESET); endproperty
    property p_once; o_vector_valid && o_vector == IPX_V_RESET
        |-> $past(i_sys_reset_trig) && !$past(i_sys_reset_trig, 2); endproperty
    property p_fix; fix_go && !i_cond.io_seg && i_cond.align
        |-> s_win(IPX_V_ALIGN); endproperty
    property p_fio; fix_go && i_cond.io_seg && i_cond.align
        |-> s_win(IPX_V_DSTOR); endproperty
    property p_gate; o_ext_request |-> o_combined; endproperty
    property p_ext; o_vector_valid && o_vector == IPX_V_EXT
        |-> $past(o_ext_request); endproperty
    property p_mask; o_vector_valid |-> !o_ext_request; endproperty
    property p_one; o_vector_valid |-> o_vector != IPX_V_NONE; endproperty
    a_rst: assert property (p_rst) else $error("reset missed");
    a_once: assert property (p_once) else $error("reset repeat");
    a_fix: assert property (p_fix) else $error("fixed order");
    a_fio: assert property (p_fio) else $error("fixed io");
    a_gate: assert property (p_gate) else $error("ext gate");
    a_ext: assert property (p_ext) else $error("ext taken");
    a_mask: assert property (p_mask) else $error("ext unmasked");
    a_one: assert property (p_one) else $error("no winner");
endmodule // ipx_core_asserts
`default_nettype wire

/* File: tb/ipx_src_model.sv */
// Purpose: External interrupt sources
// Assumes: A request is a one-cycle pulse
// Notes:   Idle sources hold low
`timescale 1ns/1ps
`default_nettype none
module ipx_src_model (
    input  wire logic        i_clock,
    input  wire logic        i_fire,
    input  wire logic [5:0]  i_idx,
    output logic      [63:0] o_src_req = 64'h0
);
    // Pulses only, so a bit seen later proves the summary latched it
    always @(posedge i_clock) begin
        o_src_req <= i_fire ? 64'h1 << i_idx : 64'h0;
    end
endmodule // ipx_src_model
`default_nettype wire

/* File: tb/ipx_core_tb_top.sv */
// Purpose: Self-checking bench for the interrupt priority block
// Assumes: Bus timing and map as handed over by the designer
// Notes:   Ordered cases run from one table, two more follow it directly
`timescale 1ns/1ps
`default_nettype none
module ipx_core_tb_top
    import ipx_pkg::*;
;
    logic        i_clock = 1'h0;
    logic        i_srst  = 1'h1;
    logic [7:0]  av_a    = 8'h00;
    logic        av_rd   = 1'h0;
    logic        av_wr   = 1'h0;
    logic        bnd     = 1'h0;
    logic        rfi     = 1'h0;
    logic        fire    = 1'h0;
    logic [31:0] av_wd   = 32'h0;
    logic [31:0] rdat, av_q;
    logic [5:0]  idx     = 6'h0;
    logic [2:0]  unord   = 3'h0;
    ipx_cond_t   cnd     = 11'h0;
    ipx_cond_t   trp     = {IPX_CL_TRAP, 7'h00};
    logic [63:0] src;
    ipx_vec_t    vec;
    logic        vld, cio, xreq, comb, wreq;
    int          n_mismatch  = 0;
    int          checks_done = 0;
    // Flags: io_seg align dstor trace fp_unavail fp_enabled priv
    ipx_cond_t tc [13] = '{
        {IPX_CL_FIX_LS, 7'h38}, {IPX_CL_FIX_LS, 7'h18},
        {IPX_CL_FIX_LS, 7'h60}, {IPX_CL_FIX_LS, 7'h41},
        {IPX_CL_FP_LS, 7'h3C}, {IPX_CL_FP_LS, 7'h60},
        {IPX_CL_FP_ARITH, 7'h0E}, {IPX_CL_FP_ARITH, 7'h0A},
        {IPX_CL_FP_OTHER, 7'h08}, {IPX_CL_RFI_MTMSR, 7'h03},
        {IPX_CL_RFI_MTMSR, 7'h02}, {IPX_CL_UNDEF, 7'h00},
        {IPX_CL_SVC, 7'h00}};
    ipx_vec_t tv [13] = '{IPX_V_ALIGN, IPX_V_DSTOR, IPX_V_DSTOR,
        IPX_V_DSTOR, IPX_V_FPUNAV, IPX_V_ALIGN, IPX_V_FPUNAV, IPX_V_PROG_FP,
        IPX_V_TRACE, IPX_V_PROG_PRIV, IPX_V_PROG_FP, IPX_V_PROG_INV,
        IPX_V_SVC};
    always #20 i_clock = ~i_clock;
    ipx_core #(.NSRC(IPX_NSRC)) dut_u (
        .i_clock(i_clock), .i_srst(i_srst), .i_avs_address(av_a),
        .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_src_req(src),
        .i_sys_reset_trig(unord[2]), .i_mcheck(unord[1]),
        .i_boundary(bnd), .i_cond(cnd), .i_fetch_fail(unord[0]),
        .i_rfi(rfi), .o_vector(vec), .o_vector_valid(vld),
        .o_cause_io(cio), .o_ext_request(xreq), .o_combined(comb));
    ipx_src_model src_u (
        .i_clock(i_clock), .i_fire(fire), .i_idx(idx), .o_src_req(src));
    task automatic stop_test();
        if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Request raised after an edge, held until waitrequest is low there
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge i_clock);
        av_a <= a;
        av_wd <= d;
        av_wr <= w;
        av_rd <= !w;
        @(posedge i_clock);
        while (wreq !== 1'h0) @(posedge i_clock);
        av_q = rdat;
        av_wr <= 1'h0;
        av_rd <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'h0, 32'h0);
        cmp(av_q, e);
    endtask
    task automatic ev(input ipx_cond_t c, input logic [2:0] u,
                      input ipx_vec_t v);
        @(posedge i_clock);
        cnd <= c;
        unord <= u;
        bnd <= 1'h1;
        @(posedge i_clock);
        bnd <= 1'h0;
        @(negedge i_clock);
        cmp({26'h0, vld, cio, vec},
            {26'h0, 1'h1, v == IPX_V_ALIGN && c.io_seg, v});
    endtask
    task automatic lvl(input logic [1:0] e);
        @(negedge i_clock);
        cmp({30'h0, comb, xreq}, {30'h0, e});
    endtask
    task automatic pls(input logic [5:0] n);
        @(posedge i_clock);
        fire <= 1'h1;
        idx <= n;
        @(posedge i_clock);
        fire <= 1'h0;
        repeat (2) @(posedge i_clock);
    endtask
    initial begin
        repeat (6) @(posedge i_clock);
        i_srst <= 1'h0;
        rd(IPX_OFF_CTRL, IPX_CTRL_RST);
        foreach (tc[i]) ev(tc[i], 3'h0, tv[i]);
        ev({IPX_CL_FP_LS, 7'h50}, 3'h0, IPX_V_DSTOR);
        ev({IPX_CL_PRIV, 7'h09}, 3'h0, IPX_V_PROG_PRIV);
        rd(IPX_OFF_CAUSE, 32'h0000_4000);
        ev(trp, 3'h1, IPX_V_PROG_TRAP);
        ev(11'h0, 3'h1, IPX_V_ISTOR);
        ev(trp, 3'h2, IPX_V_MCHECK);
        ev(trp, 3'h2, IPX_V_PROG_TRAP);
        rd(IPX_OFF_CTRL, 32'h0);
        bus(IPX_OFF_MASK0, 1'h1, 32'h6);
        bus(IPX_OFF_MASK0, 1'h1, 32'h1);
        rd(IPX_OFF_MASK0, 32'h1);
        rd(IPX_OFF_MASK0, 32'h1);
        rd(8'h08, 32'h0);
        pls(6'h21);
        lvl(2'h0);
        pls(6'h00);
        lvl(2'h2);
        rd(IPX_OFF_SUM1, 32'h2);
        rd(IPX_OFF_SUM1, 32'h0);
        bus(IPX_OFF_SUM0, 1'h1, 32'h4);
        bus(IPX_OFF_CTRL, 1'h1, 32'h1);
        lvl(2'h3);
        ev(trp, 3'h0, IPX_V_PROG_TRAP);
        lvl(2'h2);
        @(posedge i_clock);
        rfi <= 1'h1;
        @(posedge i_clock);
        rfi <= 1'h0;
        ev(11'h0, 3'h0, IPX_V_EXT);
        rd(IPX_OFF_SUM0, 32'h5);
        lvl(2'h0);
        // Source pulse lands on the very edge that clears the word
        fork
            pls(6'h02);
            begin
                @(posedge i_clock);
                rd(IPX_OFF_SUM0, 32'h0);
            end
        join
        rd(IPX_OFF_SUM0, 32'h4);
        ev(trp, 3'h4, IPX_V_RESET);
        ev(trp, 3'h4, IPX_V_PROG_TRAP);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        n_mismatch++;
        stop_test();
    end
endmodule // ipx_core_tb_top
bind ipx_core ipx_core_asserts chk_u (
    .i_clock(i_clock), .i_srst(i_srst), .i_sys_reset_trig(i_sys_reset_trig),
    .i_mcheck(i_mcheck), .i_boundary(i_boundary), .i_cond(i_cond),
    .o_vector(o_vector), .o_vector_valid(o_vector_valid),
    .o_ext_request(o_ext_request), .o_combined(o_combined));
`default_nettype wire
